// ==== bench/status_blocks_model.sv ====
`timescale 1ns/1ps
`include "led_combiner_regs.vh"
// internal blocks: report the states asked for, follow swap and reset
module status_blocks_model (
    input wire clk,
    input wire swap,
    input wire rst_n,
    input wire down,
    input wire [8:0] want,
    output wire [8:0] st,
    output wire [1:0] act0,
    output wire [1:0] act1
);
    logic [1:0] a0 = `ACT_ACTIVE;
    logic [1:0] a1 = `ACT_READY;
    // control blocks sit in self test while their reset is held
    assign st = rst_n ? want : {want[8:6], `BLK_START, `BLK_START};
    // a swap trades roles; a block taken down reports passive
    always @(posedge clk) if (swap) {a0, a1} <= {a1, a0};
    assign act0 = a0;
    assign act1 = down ? `ACT_PASSIVE : a1;
endmodule

// ==== bench/status_led_checker.sv ====
`timescale 1ns/1ps
`include "led_combiner_regs.vh"
// checks the led combination and the button actions at the ports
module status_led_checker (
    input wire CLOCK,
    input wire ARST_N,
    input wire [2:0] CTRL0_STATE,
    input wire [2:0] CTRL1_STATE,
    input wire [2:0] ALARM_STATE,
    input wire [1:0] CTRL0_ACT,
    input wire [1:0] CTRL1_ACT,
    input wire CTRL1_PRESENT,
    input wire [2:0] RED_REQ,
    input wire [2:0] GREEN_REQ,
    input wire BUTTON_N,
    input wire LED_RED,
    input wire LED_GREEN,
    input wire SWAP_PULSE,
    input wire CTRL_RESET_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // rest of the module ok; the xor is 3 only for an active and ready pair
    wire ok = CTRL1_STATE == `BLK_OK && ALARM_STATE == `BLK_OK;
    wire pair = CTRL1_PRESENT && (CTRL0_ACT ^ CTRL1_ACT) == 2'h3;
    swap_on_pair_a: assert property ($fell(BUTTON_N) && pair |-> ##3 SWAP_PULSE)
        else $error("press gave no swap");
    reset_both_a: assert property ($fell(BUTTON_N) && !pair |-> ##3 !CTRL_RESET_N)
        else $error("press gave no reset");
    fault_wins_a: assert property (ALARM_STATE == `BLK_FAULT |=> LED_RED && !LED_GREEN)
        else $error("fault not shown");
    ctrl_dead_a: assert property (CTRL0_STATE == `BLK_OFF && ok |=> LED_RED && !LED_GREEN)
        else $error("dead block not shown");
    sleep_dark_a: assert property ({ALARM_STATE, CTRL1_STATE, CTRL0_STATE} == 9'h000
        |=> !LED_RED && !LED_GREEN) else $error("leds lit in sleep");
    all_ok_a: assert property (CTRL0_STATE == `BLK_OK && ok |=> !LED_RED && LED_GREEN)
        else $error("normal state not shown");
    starting_a: assert property (CTRL0_STATE == `BLK_START && ok |=> LED_RED && LED_GREEN)
        else $error("start not shown");
    or_and_a: assert property (CTRL0_STATE == `BLK_WAIT && ok |=>
        LED_RED == |($past(RED_REQ) & {1'b1, $past(CTRL1_PRESENT), 1'b1})
        && LED_GREEN == &($past(GREEN_REQ) | {1'b0, !$past(CTRL1_PRESENT), 1'b0}))
        else $error("requests not combined");
    cover property (SWAP_PULSE);
    cover property (!CTRL1_PRESENT && LED_GREEN);
    cover property (!CTRL_RESET_N);
    cover property (LED_RED && LED_GREEN);
endmodule
bind status_led_combiner status_led_checker status_led_checker_i (.CLOCK(CLOCK),
    .ARST_N(ARST_N), .CTRL0_STATE(CTRL0_STATE), .CTRL1_STATE(CTRL1_STATE),
    .ALARM_STATE(ALARM_STATE), .CTRL0_ACT(CTRL0_ACT), .CTRL1_ACT(CTRL1_ACT),
    .CTRL1_PRESENT(CTRL1_PRESENT), .RED_REQ(RED_REQ), .GREEN_REQ(GREEN_REQ),
    .BUTTON_N(BUTTON_N), .LED_RED(LED_RED), .LED_GREEN(LED_GREEN),
    .SWAP_PULSE(SWAP_PULSE), .CTRL_RESET_N(CTRL_RESET_N));

// ==== bench/status_led_combiner_tb_top.sv ====
`timescale 1ns/1ps
module status_led_combiner_tb_top;
    logic clock = 0, arst_n = 0, button_n = 1, down = 0, present = 1;
    logic [8:0] want = 9'h000;
    logic [2:0] red_req = 3'h0, green_req = 3'h0;
    wire [8:0] st;
    wire [1:0] a0, a1;
    wire red, green, swap, crst_n;
    int bad_count = 0, total_checks = 0, n;
    status_blocks_model status_blocks_model_i (.clk(clock), .swap(swap), .rst_n(crst_n),
        .down(down), .want(want), .st(st), .act0(a0), .act1(a1));
    status_led_combiner #(.BLINK_HALF_CYC(8)) status_led_combiner_i (.CLOCK(clock),
        .ARST_N(arst_n), .CTRL0_STATE(st[2:0]), .CTRL1_STATE(st[5:3]), .ALARM_STATE(st[8:6]),
        .CTRL0_ACT(a0), .CTRL1_ACT(a1), .CTRL1_PRESENT(present), .RED_REQ(red_req),
        .GREEN_REQ(green_req), .BUTTON_N(button_n), .LED_RED(red), .LED_GREEN(green),
        .SWAP_PULSE(swap), .CTRL_RESET_N(crst_n));
    initial forever #20 clock = ~clock;
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // a wait that ran out ends the run
    task bound(input int k, input int lim);
        if (k >= lim) begin
            bad_count++;
            print_verdict;
        end
    endtask
    task leds(input logic [8:0] s, input logic [2:0] r, g, input logic [1:0] e);
        @(negedge clock);
        want = s;
        red_req = r;
        green_req = g;
        repeat (2) @(negedge clock);
        check("leds", {red, green}, e);
    endtask
    // two block variant: the absent block is ignored in states and in both votes
    task absent;
        present = 0;
        leds(9'h09A, 3'h0, 3'h7, 2'h1);
        leds(9'h094, 3'h2, 3'h5, 2'h1);
        present = 1;
    endtask
    // state combinations; requests set against the expected answer except in the all ok row and the mixed rows
    task states;
        leds(9'h000, 3'h7, 3'h7, 2'h0);
        leds(9'h092, 3'h0, 3'h7, 2'h1);
        leds(9'h0D2, 3'h0, 3'h7, 2'h2);
        leds(9'h090, 3'h0, 3'h7, 2'h2);
        leds(9'h091, 3'h0, 3'h0, 2'h3);
        leds(9'h094, 3'h4, 3'h6, 2'h2);
        leds(9'h094, 3'h0, 3'h7, 2'h1);
    endtask
    // blinking green, and red in step with it while loading
    task blink(input logic [8:0] s, input logic both);
        logic g0;
        want = s;
        repeat (2) @(negedge clock);
        g0 = green;
        n = 0;
        repeat (40) begin
            @(negedge clock);
            n += (green !== g0);
            g0 = green;
            if (both) check("phase", red, green);
        end
        check("toggles", n >= 4, 1'b1);
    endtask
    // one press: swap for an active and ready pair, else a timed reset
    task press(input logic pair);
        button_n = 0;
        n = 0;
        while (swap !== 1'b1 && crst_n !== 1'b0 && n < 8) begin
            @(negedge clock);
            n++;
        end
        bound(n, 8);
        check("latency", n, 3);
        check("swap", swap, pair);
        n = 0;
        while (crst_n === 1'b0 && n < 40) begin
            @(negedge clock);
            n++;
        end
        bound(n, 40);
        check("rst_len", n, pair ? 0 : 25);
        @(negedge clock);
        check("swap_len", swap, 1'b0);
        check("act0", a0, 2'h1);
        button_n = 1;
        repeat (4) @(negedge clock);
    endtask
    initial begin
        repeat (20) @(negedge clock);
        check("reset", {red, green}, 0);
        arst_n = 1;
        states;
        absent;
        blink(9'h152, 1);
        blink(9'h112, 0);
        press(1);
        down = 1;
        press(0);
        print_verdict;
    end
endmodule

// ==== pkg/led_combiner_regs.vh ====
`ifndef LED_COMBINER_REGS_VH
`define LED_COMBINER_REGS_VH

// block state codes reported by each internal block
`define BLK_OFF 3'h0
`define BLK_START 3'h1
`define BLK_OK 3'h2
`define BLK_FAULT 3'h3
`define BLK_WAIT 3'h4
`define BLK_LOAD 3'h5
`define BLK_STATE_W 3

// control block activity codes
`define ACT_PASSIVE 2'h0
`define ACT_READY 2'h1
`define ACT_ACTIVE 2'h2
`define ACT_W 2

// blink half period in ns and derived cycle count at 25 MHz (40 ns)
`define BLINK_HALF_NS 250000000
`define CLK_PERIOD_NS 40
`define BLINK_HALF_CYC (`BLINK_HALF_NS / `CLK_PERIOD_NS)

// reset pulse width to the control blocks, in ns, least time
`define RST_PULSE_NS 1000
`define RST_PULSE_CYC ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/blink_phase.v ====
`timescale 1ns/1ps
`include "led_combiner_regs.vh"
// shared blink phase generator: one toggling phase for every blinking led
module blink_phase #(
    parameter HALF_CYC = `BLINK_HALF_CYC,
    parameter CNT_W = 24
) (
    input wire clk,
    input wire arst_n,
    output reg phase_r
);
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;

    // free running divider; phase flips every half period
    always @* begin
        if (cnt_r == HALF_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            cnt_nxt = {CNT_W{1'b0}};
        end else begin
            cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= {CNT_W{1'b0}};
            phase_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            if (cnt_r == HALF_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                phase_r <= ~phase_r;
            end
        end
    end
endmodule

// ==== rtl/status_led_combiner.v ====
`timescale 1ns/1ps
`include "led_combiner_regs.vh"

module status_led_combiner #(
    parameter BLINK_HALF_CYC = `BLINK_HALF_CYC,
    parameter RST_PULSE_CYC = `RST_PULSE_CYC
) (
    input wire CLOCK,
    input wire ARST_N,
    input wire [2:0] CTRL0_STATE,
    input wire [2:0] CTRL1_STATE,
    input wire [2:0] ALARM_STATE,
    input wire [1:0] CTRL0_ACT,
    input wire [1:0] CTRL1_ACT,
    input wire CTRL1_PRESENT,
    input wire [2:0] RED_REQ,
    input wire [2:0] GREEN_REQ,
    input wire BUTTON_N,
    output reg LED_RED,
    output reg LED_GREEN,
    output reg SWAP_PULSE,
    output reg CTRL_RESET_N
);
    // pin synchroniser for the front panel button (active low)
    reg btn_s1_r;
    reg btn_s2_r;
    reg btn_d_r;
    // request and state inputs come from on-chip logic on CLOCK
    reg [7:0] rst_cnt_r;
    reg [7:0] rst_cnt_nxt;
    reg red_nxt;
    reg green_nxt;
    wire phase;
    wire press;
    wire any_fault;
    wire any_load;
    wire any_wait;
    wire any_start;
    wire all_ok;
    wire all_off;
    wire ctrl_bad;
    wire can_swap;
    wire req_red;
    wire req_green;
    // per block decode; ctrl1 terms are masked by its presence
    wire ctrl0_fault;
    wire ctrl0_off;
    wire ctrl0_start;
    wire ctrl0_ok;
    wire ctrl1_fault;
    wire ctrl1_off;
    wire ctrl1_start;
    wire ctrl1_ok;
    wire alarm_fault;
    wire alarm_off;
    wire alarm_start;
    wire alarm_ok;
    // roles of the redundant control pair
    wire ctrl0_active;
    wire ctrl0_ready;
    wire ctrl1_active;
    wire ctrl1_ready;

    // true when a block reports the given state
    function is_state;
        input [2:0] st;
        input [2:0] code;
        begin
            is_state = (st == code);
        end
    endfunction

    // true when a control block holds the given role
    function is_role;
        input [1:0] act;
        input [1:0] code;
        begin
            is_role = (act == code);
        end
    endfunction

    // one divider feeds both leds so their blinking never drifts apart
    blink_phase #(
        .HALF_CYC(BLINK_HALF_CYC),
        .CNT_W(24)
    ) u_blink (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .phase_r(phase)
    );

    // two flops settle the asynchronous button, a third remembers the last level
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            btn_s1_r <= 1'b1;
            btn_s2_r <= 1'b1;
            btn_d_r <= 1'b1;
        end else begin
            btn_s1_r <= BUTTON_N;
            btn_s2_r <= btn_s1_r;
            btn_d_r <= btn_s2_r;
        end
    end

    // press is the falling edge of the synchronised button
    assign press = btn_d_r & ~btn_s2_r;

    // control block 0 decode
    assign ctrl0_fault = is_state(CTRL0_STATE, `BLK_FAULT);
    assign ctrl0_off = is_state(CTRL0_STATE, `BLK_OFF);
    assign ctrl0_start = is_state(CTRL0_STATE, `BLK_START);
    assign ctrl0_ok = is_state(CTRL0_STATE, `BLK_OK);

    // an absent second control block is masked here, and all_ok and all_off test its presence again, so no summary trips on it
    assign ctrl1_fault = CTRL1_PRESENT & is_state(CTRL1_STATE, `BLK_FAULT);
    assign ctrl1_off = CTRL1_PRESENT & is_state(CTRL1_STATE, `BLK_OFF);
    assign ctrl1_start = CTRL1_PRESENT & is_state(CTRL1_STATE, `BLK_START);
    assign ctrl1_ok = CTRL1_PRESENT & is_state(CTRL1_STATE, `BLK_OK);

    // alarm bridge block decode
    assign alarm_fault = is_state(ALARM_STATE, `BLK_FAULT);
    assign alarm_off = is_state(ALARM_STATE, `BLK_OFF);
    assign alarm_start = is_state(ALARM_STATE, `BLK_START);
    assign alarm_ok = is_state(ALARM_STATE, `BLK_OK);

    // roles of the redundant pair, used only by the button
    assign ctrl0_active = is_role(CTRL0_ACT, `ACT_ACTIVE);
    assign ctrl0_ready = is_role(CTRL0_ACT, `ACT_READY);
    assign ctrl1_active = is_role(CTRL1_ACT, `ACT_ACTIVE);
    assign ctrl1_ready = is_role(CTRL1_ACT, `ACT_READY);

    // summaries; an absent block is fine and takes no part
    assign ctrl_bad = ctrl0_fault | ctrl0_off | ctrl1_fault | ctrl1_off;
    assign any_fault = ctrl0_fault | ctrl1_fault | alarm_fault;
    assign any_load = is_state(ALARM_STATE, `BLK_LOAD);
    assign any_wait = is_state(ALARM_STATE, `BLK_WAIT);
    assign any_start = ctrl0_start | ctrl1_start | alarm_start;
    assign all_ok = ctrl0_ok & alarm_ok & (~CTRL1_PRESENT | ctrl1_ok);
    // whole module asleep or unpowered: every fitted block reports off
    assign all_off = ctrl0_off & alarm_off & (~CTRL1_PRESENT | ctrl1_off);
    // absent block does not vote: its green counts as on, its red as off
    assign req_red = RED_REQ[0] | RED_REQ[2] | (CTRL1_PRESENT & RED_REQ[1]);
    assign req_green = GREEN_REQ[0] & GREEN_REQ[2] & (~CTRL1_PRESENT | GREEN_REQ[1]);
    // swap needs both blocks fitted, one active beside one ready, either way round
    assign can_swap = CTRL1_PRESENT
        & ((ctrl0_active & ctrl1_ready) | (ctrl1_active & ctrl0_ready));

    // led priority: off, fault, bad control block, download, wait, start, ok
    always @* begin
        red_nxt = req_red;
        green_nxt = req_green;
        if (all_off) begin
            red_nxt = 1'b0;
            green_nxt = 1'b0;
        end else if (any_fault) begin
            red_nxt = 1'b1;
            green_nxt = 1'b0;
        end else if (ctrl_bad) begin
            red_nxt = 1'b1;
            green_nxt = 1'b0;
        end else if (any_load) begin
            red_nxt = phase;
            green_nxt = phase;
        end else if (any_wait) begin
            red_nxt = req_red; // red left to the requests, on or off
            green_nxt = phase;
        end else if (any_start) begin
            red_nxt = 1'b1; // amber: both on
            green_nxt = 1'b1;
        end else if (all_ok) begin
            red_nxt = 1'b0;
            green_nxt = 1'b1;
        end else begin
            red_nxt = req_red; // mixed states follow the requests
            green_nxt = req_green;
        end
    end

    // reset stretch counter: holds the control block reset for a minimum width
    // a press without a swap pair during a running pulse reloads the count, so the pulse restarts
    always @* begin
        if (press && !can_swap) begin
            rst_cnt_nxt = RST_PULSE_CYC[7:0];
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_nxt = rst_cnt_r - 8'h01;
        end else begin
            rst_cnt_nxt = 8'h00;
        end
    end

    // every led comes straight from a flop; leds follow the inputs by one clock
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            LED_RED <= 1'b0;
            LED_GREEN <= 1'b0;
        end else begin
            LED_RED <= red_nxt;
            LED_GREEN <= green_nxt;
        end
    end

    // button actions: one swap pulse or one stretched reset per press
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SWAP_PULSE <= 1'b0;
            CTRL_RESET_N <= 1'b1;
            rst_cnt_r <= 8'h00;
        end else begin
            SWAP_PULSE <= press & can_swap;
            rst_cnt_r <= rst_cnt_nxt;
            CTRL_RESET_N <= (rst_cnt_nxt == 8'h00);
        end
    end
endmodule
